// ===== src/dssp_pkg.sv
`timescale 1ns/100ps
`default_nettype none

package dssp_pkg;

  localparam int          NUM_SETS      = 4;
  localparam int          AXI_AW        = 8;

  // Register byte offsets
  localparam logic [7:0]  OFF_CTRL      = 8'h00;
  localparam logic [7:0]  OFF_STATUS    = 8'h04;
  localparam logic [3:0]  SET_BASE_HI   = 4'h1;
  localparam logic [1:0]  FLD_LEN       = 2'h0;
  localparam logic [1:0]  FLD_WID       = 2'h1;
  localparam logic [1:0]  FLD_CNT       = 2'h2;

  // Control register fields
  localparam int          CTRL_START    = 0;
  localparam int          CTRL_STOP     = 1;
  localparam int          CTRL_SEL_LO   = 4;

  // Status register fields
  localparam int          ST_ARMED      = 0;
  localparam int          ST_RUN        = 1;
  localparam int          ST_OUT        = 2;
  localparam int          ST_STOP_PEND  = 3;
  localparam int          ST_SEL_LO     = 4;
  localparam int          ST_REPS_LO    = 16;

  // Setting ranges
  localparam logic [15:0] MIN_LEN       = 16'h0002;
  localparam logic [15:0] MIN_WID       = 16'h0001;
  localparam logic [15:0] MAX_WID       = 16'hFFFE;

  // Reset defaults, set 0 in the lowest slot
  localparam logic [3:0][15:0] DEF_LEN  = {16'h2710, 16'h03E8, 16'h0014, 16'h000A};
  localparam logic [3:0][15:0] DEF_WID  = {16'h1388, 16'h01F4, 16'h000A, 16'h0005};
  localparam logic [3:0][15:0] DEF_CNT  = {16'h000A, 16'h000A, 16'h0000, 16'h0000};

  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [3:0] {
    DSSP_IDLE  = 4'h1,
    DSSP_ARMED = 4'h2,
    DSSP_ON    = 4'h4,
    DSSP_OFF   = 4'h8
  } dssp_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } dssp_sync_t;

endpackage

module dssp_pin_sync (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Pin side
  input  wire logic pin,
  // Filtered level
  output logic      level
);

  dssp_pkg::dssp_sync_t r;
  dssp_pkg::dssp_sync_t n;

  always_comb begin
    n    = r;
    n.s1 = pin;
    n.s2 = r.s1;
    n.s3 = r.s2;
    // Level changes once second and third stages agree
    if (r.s2 == r.s3) begin
      n.lvl = r.s3;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign level = r.lvl;

endmodule

`default_nettype wire

// ===== src/dssp_top.sv
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/100ps
`default_nettype none

module dssp_top (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  // AXI4-Lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Drive pulse generator
  input  wire logic        drive_pulse_in,
  input  wire logic        drive_active_in,
  // Sensor connector
  output logic             split_sync_output
);

  typedef struct packed {
    dssp_pkg::dssp_state_t state;
    logic [3:0][15:0]      len;
    logic [3:0][15:0]      wid;
    logic [3:0][15:0]      cnt;
    logic [1:0]            sel;
    logic [15:0]           w_len;
    logic [15:0]           w_wid;
    logic [15:0]           w_cnt;
    logic [15:0]           pos;
    logic [15:0]           reps;
    logic                  out;
    logic                  stop_pend;
    logic                  pulse_prev;
    logic                  aw_held;
    logic [7:0]            awaddr;
    logic                  w_held;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
  } dssp_regs_t;

  dssp_regs_t r;
  dssp_regs_t n;

  logic       pulse_lvl;
  logic       drive_on;

  dssp_pin_sync u_pulse_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (drive_pulse_in),
    .level   (pulse_lvl)
  );

  dssp_pin_sync u_active_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (drive_active_in),
    .level   (drive_on)
  );

  // Byte-lane merge of a 16-bit setting
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb);
    logic [15:0] v;
    v = old;
    if (strb[0]) begin
      v[7:0] = data[7:0];
    end
    if (strb[1]) begin
      v[15:8] = data[15:8];
    end
    return v;
  endfunction

  // Address falls on a setting field
  function automatic logic set_hit(input logic [7:0] a);
    logic [3:0] hi;
    hi = a[7:4] - dssp_pkg::SET_BASE_HI;
    return (a[7:4] >= dssp_pkg::SET_BASE_HI) && (hi < 4'(dssp_pkg::NUM_SETS))
           && (a[3:2] != 2'h3);
  endfunction

  // Set index of a setting address
  function automatic logic [1:0] set_idx(input logic [7:0] a);
    logic [3:0] hi;
    hi = a[7:4] - dssp_pkg::SET_BASE_HI;
    return hi[1:0];
  endfunction

  // Status word as software sees it
  function automatic logic [31:0] status_word(input dssp_regs_t s);
    logic [31:0] v;
    v                             = 32'h0000_0000;
    v[dssp_pkg::ST_ARMED]         = (s.state == dssp_pkg::DSSP_ARMED);
    v[dssp_pkg::ST_RUN]           = (s.state == dssp_pkg::DSSP_ON) ||
                                    (s.state == dssp_pkg::DSSP_OFF);
    v[dssp_pkg::ST_OUT]           = s.out;
    v[dssp_pkg::ST_STOP_PEND]     = s.stop_pend;
    v[dssp_pkg::ST_SEL_LO +: 2]   = s.sel;
    v[dssp_pkg::ST_REPS_LO +: 16] = s.reps;
    return v;
  endfunction

  // Register image loaded at reset
  function automatic dssp_regs_t reset_image();
    dssp_regs_t v;
    v       = '0;
    v.state = dssp_pkg::DSSP_IDLE;
    v.len   = dssp_pkg::DEF_LEN;
    v.wid   = dssp_pkg::DEF_WID;
    v.cnt   = dssp_pkg::DEF_CNT;
    return v;
  endfunction

  always_comb begin
    logic        pulse_edge;
    logic        do_write;
    logic        start_req;
    logic        stop_req;
    logic [1:0]  start_sel;
    logic [1:0]  idx;
    logic [15:0] v;
    logic        ok;
    logic [15:0] reps_inc;

    pulse_edge = 1'b0;
    do_write   = 1'b0;
    start_req  = 1'b0;
    stop_req   = 1'b0;
    start_sel  = 2'h0;
    idx        = 2'h0;
    v          = 16'h0000;
    ok         = 1'b1;
    reps_inc   = 16'h0000;
    n          = r;

    // Drive pulse edge from the filtered pin level
    n.pulse_prev = pulse_lvl;
    pulse_edge   = pulse_lvl & ~r.pulse_prev;

    // Write address and data captured in either order
    if (s_axi_awvalid && s_axi_awready) begin
      n.aw_held = 1'b1;
      n.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      n.w_held = 1'b1;
      n.wdata  = s_axi_wdata;
      n.wstrb  = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end

    do_write = r.aw_held && r.w_held && !r.bvalid;
    if (do_write) begin
      n.aw_held = 1'b0;
      n.w_held  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = dssp_pkg::RESP_OKAY;
      if (r.awaddr == dssp_pkg::OFF_CTRL) begin
        if (r.wstrb[0]) begin
          // Command takes effect on the cycle the write completes
          start_req = r.wdata[dssp_pkg::CTRL_START];
          stop_req  = r.wdata[dssp_pkg::CTRL_STOP];
          start_sel = r.wdata[dssp_pkg::CTRL_SEL_LO +: 2];
        end
      end else if (r.awaddr == dssp_pkg::OFF_STATUS) begin
        n.bresp = dssp_pkg::RESP_OKAY;
      end else if (set_hit(r.awaddr)) begin
        idx = set_idx(r.awaddr);
        case (r.awaddr[3:2])
          dssp_pkg::FLD_LEN: begin
            v  = merge16(r.len[idx], r.wdata, r.wstrb);
            ok = (v >= dssp_pkg::MIN_LEN);
            if (ok) begin
              n.len[idx] = v;
            end
          end
          dssp_pkg::FLD_WID: begin
            v  = merge16(r.wid[idx], r.wdata, r.wstrb);
            ok = (v >= dssp_pkg::MIN_WID) && (v <= dssp_pkg::MAX_WID);
            if (ok) begin
              n.wid[idx] = v;
            end
          end
          default: begin
            v          = merge16(r.cnt[idx], r.wdata, r.wstrb);
            n.cnt[idx] = v;
          end
        endcase
        if (!ok) begin
          n.bresp = dssp_pkg::RESP_SLVERR;
        end
      end else begin
        n.bresp = dssp_pkg::RESP_SLVERR;
      end
    end

    // Read channel
    if (s_axi_rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      n.rvalid = 1'b1;
      n.rresp  = dssp_pkg::RESP_OKAY;
      n.rdata  = 32'h0000_0000;
      if (s_axi_araddr == dssp_pkg::OFF_CTRL) begin
        n.rdata = 32'h0000_0000;
      end else if (s_axi_araddr == dssp_pkg::OFF_STATUS) begin
        n.rdata = status_word(r);
      end else if (set_hit(s_axi_araddr)) begin
        idx = set_idx(s_axi_araddr);
        case (s_axi_araddr[3:2])
          dssp_pkg::FLD_LEN: n.rdata[15:0] = r.len[idx];
          dssp_pkg::FLD_WID: n.rdata[15:0] = r.wid[idx];
          default:           n.rdata[15:0] = r.cnt[idx];
        endcase
      end else begin
        n.rresp = dssp_pkg::RESP_SLVERR;
      end
    end

    // Split pulse generator
    reps_inc = r.reps + 16'h0001;
    case (r.state)
      dssp_pkg::DSSP_IDLE: begin
        n.out       = 1'b0;
        n.stop_pend = 1'b0;
        if (start_req && !stop_req) begin
          // Snapshot of the selected set, fresh counters
          n.sel   = start_sel;
          n.w_len = r.len[start_sel];
          n.w_wid = r.wid[start_sel];
          n.w_cnt = r.cnt[start_sel];
          n.pos   = 16'h0000;
          n.reps  = 16'h0000;
          n.state = dssp_pkg::DSSP_ARMED;
        end
      end
      dssp_pkg::DSSP_ARMED: begin
        if (stop_req) begin
          n.state = dssp_pkg::DSSP_IDLE;
        end else if (drive_on && pulse_edge) begin
          // First drive pulse after arming, with the drive active, raises the output
          n.out   = 1'b1;
          n.pos   = 16'h0001;
          n.state = dssp_pkg::DSSP_ON;
        end
      end
      dssp_pkg::DSSP_ON: begin
        if (stop_req) begin
          n.stop_pend = 1'b1;
        end
        if (!drive_on) begin
          n.out   = 1'b0;
          n.state = dssp_pkg::DSSP_IDLE;
        end else if (pulse_edge) begin
          // Positions counted in filtered drive pulse edges only
          if (r.pos == r.w_wid) begin
            n.out  = 1'b0;
            n.reps = reps_inc;
            n.pos  = r.pos + 16'h0001;
            if ((r.w_cnt != 16'h0000) && (reps_inc == r.w_cnt)) begin
              n.state = dssp_pkg::DSSP_IDLE;
            end else if (r.stop_pend || stop_req) begin
              n.state = dssp_pkg::DSSP_IDLE;
            end else begin
              n.state = dssp_pkg::DSSP_OFF;
            end
          end else begin
            n.pos = r.pos + 16'h0001;
          end
        end
      end
      dssp_pkg::DSSP_OFF: begin
        if (!drive_on) begin
          n.out   = 1'b0;
          n.state = dssp_pkg::DSSP_IDLE;
        end else if (stop_req) begin
          // Output already low, stop at once
          n.state = dssp_pkg::DSSP_IDLE;
        end else if (pulse_edge) begin
          if (r.pos == r.w_len) begin
            n.out   = 1'b1;
            n.pos   = 16'h0001;
            n.state = dssp_pkg::DSSP_ON;
          end else begin
            n.pos = r.pos + 16'h0001;
          end
        end
      end
      default: begin
        n.out   = 1'b0;
        n.state = dssp_pkg::DSSP_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= reset_image();
    end else begin
      r <= n;
    end
  end

  // Bus handshakes
  assign s_axi_awready     = !r.aw_held && !r.bvalid;
  assign s_axi_wready      = !r.w_held && !r.bvalid;
  assign s_axi_bvalid      = r.bvalid;
  assign s_axi_bresp       = r.bresp;
  assign s_axi_arready     = !r.rvalid;
  assign s_axi_rvalid      = r.rvalid;
  assign s_axi_rdata       = r.rdata;
  assign s_axi_rresp       = r.rresp;

  // Dedicated connector line, straight from a flip-flop
  assign split_sync_output = r.out;

endmodule

`default_nettype wire

// ===== tb/dssp_drive_model.sv
`timescale 1ns/100ps
`default_nettype none

module dssp_drive_model (
  // Clock
  input  wire logic       aclk,
  // Bench control
  input  wire logic       run,
  input  wire logic [3:0] half,
  // Drive pins
  output logic            drive_pulse_in,
  output logic            drive_active_in
);
  logic [3:0] cnt_q;

  initial begin
    drive_pulse_in = 1'b0;
    drive_active_in = 1'b0;
    cnt_q = 4'h0;
  end

  // Pulse rate follows half, so a changing half models ramps
  always @(posedge aclk) begin
    drive_active_in <= run;
    if (!run) begin
      drive_pulse_in <= 1'b0;
      cnt_q <= 4'h0;
    end else if (cnt_q >= half) begin
      cnt_q <= 4'h0;
      drive_pulse_in <= !drive_pulse_in;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule

`default_nettype wire

// ===== tb/dssp_props.sv
`timescale 1ns/100ps
`default_nettype none

module dssp_props (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  input  wire logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic        drive_pulse_in,
  input  wire logic        drive_active_in,
  input  wire logic        split_sync_output
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Cycles since the last raw drive pulse edge
  logic [7:0] since_q;
  logic       dp_q;
  always_ff @(posedge aclk) begin
    dp_q <= drive_pulse_in;
    if (!aresetn || (drive_pulse_in && !dp_q)) since_q <= 8'h00;
    else if (since_q != 8'hFF) since_q <= since_q + 8'h01;
  end

  a_reset_quiet: assert property ($rose(aresetn) |-> !split_sync_output && !s_axi_bvalid)
    else $error("outputs active right after reset");
  a_out_on_pulse: assert property ($rose(split_sync_output) |-> since_q inside {[8'h02:8'h0C]})
    else $error("split output rose away from a drive pulse");
  a_fall_on_pulse: assert property ($fell(split_sync_output) && drive_active_in |-> since_q inside {[8'h02:8'h0C]})
    else $error("split output fell away from a drive pulse");
  a_drive_stop_low: assert property (!drive_active_in [*8] |-> !split_sync_output)
    else $error("split output high without drive");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered in one cycle");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered in time");
endmodule

bind dssp_top dssp_props u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .drive_pulse_in, .drive_active_in, .split_sync_output);

`default_nettype wire

// ===== tb/test_drive_synced_split_pulse.sv
`timescale 1ns/100ps
`default_nettype none

module test_drive_synced_split_pulse;
  logic        aclk, aresetn, run, so_p, dp_p;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, dat;
  logic [3:0]  s_axi_wstrb, half;
  logic [1:0]  resp;
  wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire logic   drive_pulse_in, drive_active_in, split_sync_output;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  int error_cnt, checked, rises, hc, pc, ew, el, dcnt, l, w, c, r0;
  int dl[4] = '{10, 20, 1000, 10000};
  int dw[4] = '{5, 10, 500, 5000};
  int dc[4] = '{0, 0, 10, 10};

  dssp_top dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .drive_pulse_in, .drive_active_in, .split_sync_output);
  dssp_drive_model u_drv (.aclk, .run, .half, .drive_pulse_in, .drive_active_in);

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = !aclk;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awvalid <= 1'b1; s_axi_awaddr <= a; s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d; s_axi_bready <= 1'b1;
    fork
      begin do @(posedge aclk); while (s_axi_awready !== 1'b1); s_axi_awvalid <= 1'b0; end
      begin do @(posedge aclk); while (s_axi_wready !== 1'b1); s_axi_wvalid <= 1'b0; end
    join
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_arvalid <= 1'b1; s_axi_araddr <= a; s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    dat = s_axi_rdata; resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic drive(input int n);
    int d0;
    d0 = dcnt;
    run <= 1'b1;
    while (dcnt < d0 + n) @(posedge aclk);
    repeat (4) @(posedge aclk);
    run <= 1'b0;
    repeat (12) @(posedge aclk);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Pulse-domain model: cycle and width counted in raw drive pulses
  always @(posedge aclk) begin
    so_p <= split_sync_output;
    dp_p <= drive_pulse_in;
    if (drive_pulse_in && !dp_p) begin
      dcnt++; pc++;
      if (split_sync_output) hc++;
      half <= 4'(3 + $urandom % 7);
    end
    if (split_sync_output && !so_p) begin
      if (rises > 0 && el > 0) cmp(pc, el);
      rises++; hc = 0; pc = 0;
    end
    if (!split_sync_output && so_p && ew > 0) cmp(hc, ew);
  end

  initial begin
    #(25 * 60000);
    error_cnt++;
    wrap_up();
  end

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, run} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF; half = 4'h5; aresetn = 1'b0;
    void'($urandom(32'he8bbaf07));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      rd(8'(8'h10 + 16 * k)); cmp(dat, dl[k]);
      rd(8'(8'h14 + 16 * k)); cmp(dat, dw[k]);
      rd(8'(8'h18 + 16 * k)); cmp(dat, dc[k]);
    end
    $display("test 1 done");
    wr(8'h10, 32'h1); cmp(resp, 2'h2);
    wr(8'h14, 32'h0); cmp(resp, 2'h2);
    wr(8'h14, 32'hFFFF); cmp(resp, 2'h2);
    rd(8'h14); cmp(dat, 32'h5);
    wr(8'h0C, 32'h7); cmp(resp, 2'h2);
    rd(8'hF0); cmp(resp, 2'h2);
    $display("test 2 done");
    for (int s = 0; s < 4; s++) begin
      l = 2 + $urandom % 12; w = 1 + $urandom % (l - 1); c = 1 + $urandom % 3;
      wr(8'(8'h10 + 16 * s), l);
      wr(8'(8'h14 + 16 * s), w);
      wr(8'(8'h18 + 16 * s), c); cmp(resp, 2'h0);
      el = l; ew = w; rises = 0;
      wr(8'h00, 32'(1 + 16 * s));
      rd(8'h04);
      cmp(dat, 32'(1 + 16 * s));
      repeat (20) @(posedge aclk);
      drive(c * l + l + 1);
      cmp(rises, c);
      rd(8'h04);
      cmp(dat, 32'(c * 65536 + 16 * s));
    end
    $display("test 3 done");
    wr(8'h10, 32'd6); wr(8'h14, 32'd4); wr(8'h18, 32'd0);
    el = 6; ew = 4; rises = 0;
    wr(8'h00, 32'h1);
    run <= 1'b1;
    while (!(split_sync_output === 1'b1 && rises == 2)) @(posedge aclk);
    repeat (10) @(posedge aclk);
    ew = 0;
    run <= 1'b0;
    repeat (12) @(posedge aclk);
    cmp(split_sync_output, 1'b0);
    r0 = rises;
    drive(20);
    cmp(rises, r0);
    wr(8'h18, 32'd2);
    ew = 4;
    rises = 0;
    wr(8'h00, 32'h1);
    drive(20);
    cmp(rises, 2);
    $display("test 4 done");
    wr(8'h20, 32'd8); wr(8'h24, 32'd5); wr(8'h28, 32'd0);
    el = 8; ew = 5; rises = 0;
    wr(8'h00, 32'h11);
    run <= 1'b1;
    while (!(split_sync_output === 1'b1 && rises == 2)) @(posedge aclk);
    wr(8'h00, 32'h2);
    drive(24);
    cmp(rises, 2);
    $display("test 5 done");
    wrap_up();
  end
endmodule

`default_nettype wire
